// ==== rtl/epd_host_pkg.sv ====
/*
 constants for the e-paper host serial port: frame lengths, strap codes,
 receive state codes and sensor-link divider.
 assumes a 100 MHz core clock and a serial clock far slower than it.
*/
package epd_host_pkg;
	localparam int unsigned CORE_CLK_HZ = 100_000_000;
	localparam logic [3:0] FRAME_BITS_4W = 4'h8;
	localparam logic [3:0] FRAME_BITS_3W = 4'h9;
	localparam logic STRAP_4W = 1'b0;
	localparam logic DC_COMMAND = 1'b0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// sensor clock rate, derived half-period count
	localparam int unsigned TS_CLK_HZ = 100_000;
	localparam int unsigned TS_HALF_CYC = CORE_CLK_HZ / (2 * TS_CLK_HZ);
	localparam logic [9:0] TS_HALF_CNT = 10'(TS_HALF_CYC);
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_SHIFT = 3'b010,
		RX_DONE = 3'b100
	} rx_state_t;
endpackage

// ==== rtl/epd_serial_host_interface.sv ====
/*
 host-facing serial port of the e-paper controller: 3/4-wire write path,
 read-back drive of the serial data pin, busy flag, sensor clock generator.
 assumes the serial clock, chip select, dc and data are asynchronous pins
 sampled by core_clk_i; command decode and display logic sit downstream.
*/
`timescale 1ns/10ps
module epd_serial_host_interface
	import epd_host_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic bus_mode_strap_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic sdata_i,
	input wire logic dc_i,
	input wire logic read_en_i,
	input wire logic [7:0] read_byte_i,
	input wire logic waveform_active_i,
	input wire logic sensor_req_i,
	input wire logic temp_sensor_data_i,
	output logic sdata_o,
	output logic sdata_oe_o,
	output logic [7:0] rx_byte_o,
	output logic cmd_valid_o,
	output logic data_valid_o,
	output logic busy_o,
	output logic temp_sensor_clock_o,
	output logic temp_sensor_data_o,
	output logic temp_sensor_data_oe_o,
	output logic sensor_bit_o
);
	// three-stage synchronisers; decisions read stages 2 and 3 only
	logic [2:0] cs_s_q, cs_s_d, ck_s_q, ck_s_d, sd_s_q, sd_s_d, dc_s_q, dc_s_d, bs_s_q, bs_s_d;
	logic cs_low, ck_rise, ck_fall;
	logic ck_last_q, ck_last_d, cs_low_q, cs_low_d, strap_q, strap_d;
	always_comb begin
		cs_s_d = {cs_s_q[1:0], cs_n_i};
		bs_s_d = {bs_s_q[1:0], bus_mode_strap_i};
		ck_s_d = {ck_s_q[1:0], sclk_i};
		sd_s_d = {sd_s_q[1:0], sdata_i};
		dc_s_d = {dc_s_q[1:0], dc_i};
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cs_s_q <= 3'h7;
			ck_s_q <= 3'h0;
			sd_s_q <= 3'h0;
			dc_s_q <= 3'h0;
			bs_s_q <= 3'h0;
		end else begin
			cs_s_q <= cs_s_d;
			ck_s_q <= ck_s_d;
			sd_s_q <= sd_s_d;
			dc_s_q <= dc_s_d;
			bs_s_q <= bs_s_d;
		end
	end
	// a change counts once stages 2 and 3 agree
	assign cs_low = cs_low_q;
	assign ck_rise = ck_s_q[1] && ck_s_q[2] && !ck_last_q;
	assign ck_fall = !ck_s_q[1] && !ck_s_q[2] && ck_last_q;

	// settled levels: a pin counts as moved only once stages 2 and 3 agree,
	// so a one-stage glitch on chip select cannot end a frame early
	always_comb begin
		ck_last_d = ck_last_q;
		cs_low_d = cs_low_q;
		strap_d = strap_q;
		if (ck_s_q[1] == ck_s_q[2])
			ck_last_d = ck_s_q[2];
		if (cs_s_q[1] == cs_s_q[2])
			cs_low_d = !cs_s_q[2];
		if (bs_s_q[1] == bs_s_q[2])
			strap_d = bs_s_q[2];
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ck_last_q <= 1'b0;
			cs_low_q <= 1'b0;
			strap_q <= STRAP_4W;
		end else begin
			ck_last_q <= ck_last_d;
			cs_low_q <= cs_low_d;
			strap_q <= strap_d;
		end
	end

	// receive shifter and frame counter
	rx_state_t st_q, st_d;
	logic [8:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic mode3_q, mode3_d;
	logic dc_lat_q, dc_lat_d;
	logic [7:0] rx_q, rx_d;
	logic cmdv_q, cmdv_d, datv_q, datv_d;
	logic [3:0] frame_len;
	assign frame_len = mode3_q ? FRAME_BITS_3W : FRAME_BITS_4W;
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		mode3_d = mode3_q;
		dc_lat_d = dc_lat_q;
		rx_d = rx_q;
		cmdv_d = 1'b0;
		datv_d = 1'b0;
		unique case (st_q)
			RX_IDLE: begin
				// strap caught at frame start, never under reset
				mode3_d = (strap_q != STRAP_4W);
				cnt_d = 4'h0;
				if (cs_low)
					st_d = RX_SHIFT;
			end
			RX_SHIFT: begin
				if (!cs_low) begin
					st_d = RX_IDLE;
					cnt_d = 4'h0;
				end else if (ck_rise && !read_en_i) begin
					sh_d = {sh_q[7:0], sd_s_q[2]};
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'h0)
						dc_lat_d = dc_s_q[2];
					if (cnt_q + 4'h1 == frame_len)
						st_d = RX_DONE;
				end
			end
			RX_DONE: begin
				rx_d = sh_q[7:0];
				if (mode3_q) begin
					cmdv_d = (sh_q[8] == DC_COMMAND);
					datv_d = (sh_q[8] != DC_COMMAND);
				end else begin
					cmdv_d = (dc_lat_q == DC_COMMAND);
					datv_d = (dc_lat_q != DC_COMMAND);
				end
				cnt_d = 4'h0;
				st_d = RX_SHIFT; // next frame may follow without cs release
			end
			default: st_d = RX_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= RX_IDLE;
			sh_q <= 9'h000;
			cnt_q <= 4'h0;
			mode3_q <= 1'b0;
			dc_lat_q <= 1'b0;
			rx_q <= BYTE_RESET;
			cmdv_q <= 1'b0;
			datv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			mode3_q <= mode3_d;
			dc_lat_q <= dc_lat_d;
			rx_q <= rx_d;
			cmdv_q <= cmdv_d;
			datv_q <= datv_d;
		end
	end
	assign rx_byte_o = rx_q;
	assign cmd_valid_o = cmdv_q;
	assign data_valid_o = datv_q;

	// read-back: load on cs low, shift out after each falling edge
	logic [7:0] tx_q, tx_d;
	logic oe_q, oe_d;
	always_comb begin
		tx_d = tx_q;
		oe_d = 1'b0;
		if (cs_low && read_en_i) begin
			oe_d = 1'b1;
			if (!oe_q)
				tx_d = read_byte_i;
			else if (ck_fall)
				tx_d = {tx_q[6:0], tx_q[7]};
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_q <= BYTE_RESET;
			oe_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			oe_q <= oe_d;
		end
	end
	assign sdata_o = tx_q[7];
	assign sdata_oe_o = oe_q;

	// sensor clock divider; the device always drives this clock
	logic [9:0] div_q, div_d;
	logic tsck_q, tsck_d, sbit_q, sbit_d, busy_q, busy_d;
	logic [2:0] ts_s_q, ts_s_d;
	always_comb begin
		div_d = div_q;
		tsck_d = tsck_q;
		sbit_d = sbit_q;
		ts_s_d = {ts_s_q[1:0], temp_sensor_data_i};
		if (!sensor_req_i) begin
			div_d = 10'h000;
			tsck_d = 1'b1; // bus idle high
		end else if (div_q == TS_HALF_CNT - 10'h001) begin
			div_d = 10'h000;
			tsck_d = !tsck_q;
			if (!tsck_q && ts_s_q[1] == ts_s_q[2])
				sbit_d = ts_s_q[2]; // sample as clock rises
		end else begin
			div_d = div_q + 10'h001;
		end
		busy_d = waveform_active_i || sensor_req_i;
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= 10'h000;
			tsck_q <= 1'b1;
			sbit_q <= 1'b0;
			ts_s_q <= 3'h7;
			busy_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tsck_q <= tsck_d;
			sbit_q <= sbit_d;
			ts_s_q <= ts_s_d;
			busy_q <= busy_d;
		end
	end
	assign temp_sensor_clock_o = tsck_q;
	assign temp_sensor_data_o = 1'b0; // open drain: only ever pulls low
	assign temp_sensor_data_oe_o = 1'b0; // read-only sampling; no writes issued
	assign busy_o = busy_q;
	assign sensor_bit_o = sbit_q;
endmodule // epd_serial_host_interface

// ==== sim/epd_host_properties.sv ====
/* checker for the host serial port.
 assumes it is bound onto the design top. */
`timescale 1ns/10ps
module epd_host_properties (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic cs_n_i,
	input wire logic read_en_i,
	input wire logic waveform_active_i,
	input wire logic sensor_req_i,
	input wire logic sdata_oe_o,
	input wire logic [7:0] rx_byte_o,
	input wire logic cmd_valid_o,
	input wire logic data_valid_o,
	input wire logic busy_o,
	input wire logic temp_sensor_clock_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// any byte hand-over, and any busy cause
	wire logic v = cmd_valid_o | data_valid_o;
	wire logic act = waveform_active_i | sensor_req_i;
	sequence cs_idle; cs_n_i [*8]; endsequence
	sequence no_read; !read_en_i [*2]; endsequence
	busy_set_a: assert property (act |=> busy_o) else $error("busy low");
	busy_clr_a: assert property (!act |=> !busy_o) else $error("busy high");
	valid_excl_a: assert property (!(cmd_valid_o && data_valid_o)) else $error("two kinds");
	valid_pulse_a: assert property (v |=> !v) else $error("long valid");
	cs_ignore_a: assert property (cs_idle |-> !v) else $error("valid unselected");
	byte_hold_a: assert property ($changed(rx_byte_o) |-> v) else $error("byte moved");
	read_drive_a: assert property (no_read |-> !sdata_oe_o) else $error("stray drive");
	read_quiet_a: assert property (sdata_oe_o |-> !v) else $error("rx in read");
	ts_clock_a: assert property ($rose(sensor_req_i) |-> ##[1:502] $changed(temp_sensor_clock_o))
		else $error("sensor clock still");
endmodule // epd_host_properties
bind epd_serial_host_interface epd_host_properties chk_u (.*);

// ==== sim/epd_host_model.sv ====
/* host model driving the serial link.
 assumes clk_i is the core clock. */
`timescale 1ns/10ps
module epd_host_model (
	input wire logic clk_i,
	input wire logic line_i,
	output logic cs_n_o = 1'b1,
	output logic sclk_o = 1'b0,
	output logic sdata_o = 1'b0,
	output logic dc_o = 1'b0
);
	logic [7:0] rx_q = 8'h00;
	// host samples at sclk rise
	always @(posedge sclk_o) rx_q <= {rx_q[6:0], line_i};
	// bits n-1 down to s, s above 0 aborts; h is half period
	task automatic xfer(input int n, input logic [8:0] v, input logic dc, input int s, input int h);
		cs_n_o <= 1'b0;
		dc_o <= dc;
		repeat (4) @(posedge clk_i);
		for (int i = n - 1; i >= s; i--) begin
			sdata_o <= v[i];
			repeat (h) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (h) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
		cs_n_o <= 1'b1;
		sdata_o <= ~sdata_o; // released line must not show the last bit
		repeat (8) @(posedge clk_i);
	endtask
	// n clock pulses with cs left high; the device must ignore them
	task automatic stray(input int n, input int h);
		for (int i = 0; i < n; i++) begin
			sdata_o <= i[0];
			repeat (h) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (h) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
	endtask
endmodule // epd_host_model

// ==== sim/tb_top.sv ====
/* testbench: host model drives, a queue predicts bytes.
 assumes design and host model compiled first. */
`timescale 1ns/10ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic strap = 1'b0, rd = 1'b0, wave = 1'b0, sreq = 1'b0, tsd = 1'b1;
	logic [7:0] rbyte = 8'h00;
	logic [7:0] rxb;
	logic cs_n, sclk, hsd, dc, sdo, oe, cmdv, datav, busy;
	logic tsck, tsdo, tsoe, sbit;
	logic tsck_last = 1'b1;
	int n_tog = 0;
	int n_oe = 0;
	int t0;
	wire logic line = oe ? sdo : hsd;
	logic [8:0] exp_q[$];
	logic [8:0] b, g;
	int n_fail = 0;
	int n_compared = 0;
	always #5 core_clk_i = ~core_clk_i;
	epd_serial_host_interface dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_mode_strap_i(strap),
		.cs_n_i(cs_n), .sclk_i(sclk), .sdata_i(line), .dc_i(dc), .read_en_i(rd), .read_byte_i(rbyte),
		.waveform_active_i(wave), .sensor_req_i(sreq), .temp_sensor_data_i(tsd), .sdata_o(sdo),
		.sdata_oe_o(oe), .rx_byte_o(rxb), .cmd_valid_o(cmdv), .data_valid_o(datav), .busy_o(busy),
		.temp_sensor_clock_o(tsck), .temp_sensor_data_o(tsdo), .temp_sensor_data_oe_o(tsoe),
		.sensor_bit_o(sbit));
	// sensor clock toggles and read-drive cycles, counted once a cycle
	always @(posedge core_clk_i) begin
		if (tsck !== tsck_last)
			n_tog++;
		if (oe === 1'b1)
			n_oe++;
		tsck_last <= tsck;
	end
	epd_host_model host_u (.clk_i(core_clk_i), .line_i(line), .cs_n_o(cs_n), .sclk_o(sclk),
		.sdata_o(hsd), .dc_o(dc));
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// each hand-over must be the next predicted byte
	always @(posedge core_clk_i) if (cmdv === 1'b1 || datav === 1'b1) begin
		g = exp_q.size() ? exp_q.pop_front() : 9'bx;
		check("rx", {datav, rxb}, g);
	end
	initial begin
		void'($urandom(32'h8d48));
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		// 4-wire then 3-wire, kind from dc or flag
		for (int m = 0; m < 2; m++) begin
			strap <= m[0];
			repeat (4) @(posedge core_clk_i);
			for (int k = 0; k < 4; k++) begin
				b = {k[0], 8'($urandom)};
				exp_q.push_back(b);
				if (m == 0) host_u.xfer(8, b, k[0], 0, 8);
				else host_u.xfer(9, b, 1'b0, 0, 8);
			end
			check("left", 9'(exp_q.size()), 9'h0);
			$display("mode test done");
		end
		// cut frame gives nothing, next frame intact
		host_u.xfer(9, 9'h1a5, 1'b0, 4, 8);
		host_u.stray(9, 8);
		b = {1'b1, 8'($urandom)};
		exp_q.push_back(b);
		host_u.xfer(9, b, 1'b0, 0, 8);
		check("left", 9'(exp_q.size()), 9'h0);
		$display("abort test done");
		rd <= 1'b1;
		rbyte <= 8'($urandom);
		t0 = n_oe;
		host_u.xfer(8, 9'h0, 1'b0, 0, 20);
		check("read", {1'b0, host_u.rx_q}, {1'b0, rbyte});
		// drive stands as long as cs is low: 4 lead, 8 bits of 40, 8 tail
		check("drive", 9'(n_oe - t0), 9'(4 + 8 * 40 + 8));
		rd <= 1'b0;
		$display("read test done");
		// busy is raised by waveform activity a cycle later, whatever the link is doing
		wave <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		check("busy", {8'h0, busy}, 9'h1);
		wave <= 1'b0;
		b[0] = 1'($urandom);
		// two sensor windows with opposite data levels, so the sampled bit must move
		for (int j = 0; j < 2; j++) begin
			tsd <= b[0] ^ j[0];
			sreq <= 1'b1;
			t0 = n_tog;
			repeat (1200) @(posedge core_clk_i);
			check("busy", {8'h0, busy}, 9'h1);
			check("tsclk", 9'(n_tog - t0), 9'(1200 / epd_host_pkg::TS_HALF_CYC));
			check("tsbit", {8'h0, sbit}, {8'h0, b[0] ^ j[0]});
			check("tspin", {7'h0, tsoe, tsdo}, 9'h0);
			sreq <= 1'b0;
			repeat (3) @(posedge core_clk_i);
			check("idle", {8'h0, busy}, 9'h0);
			check("tsidle", {8'h0, tsck}, 9'h1);
		end
		$display("busy test done");
		finish_test();
	end
	// hang guard, far beyond the few thousand cycles needed
	initial begin
		#200us;
		n_fail++;
		finish_test();
	end
endmodule // tb_top
